/* logic/sterm_pkg.sv */
// Shared constants and types of the serial terminal controller
package sterm_pkg;

	// Clock and line timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINE_BAUD = 110;
	localparam int BIT_TIME_NS = 1000000000 / LINE_BAUD;
	localparam int HALF_BIT_CYCLES = BIT_TIME_NS / (2 * CLK_PERIOD_NS);

	// Frame layout, in bits and half bits
	localparam int FRAME_BITS = 11;
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 2;
	localparam logic [4:0] LAST_HALF = 5'h15;
	localparam logic [4:0] DONE_HALF = 5'h14;
	localparam logic [4:0] FIRST_DATA_HALF = 5'h02;
	localparam logic [4:0] LAST_DATA_HALF = 5'h10;
	localparam logic [4:0] STOP_HALF = 5'h12;

	// Line levels after the isolated inverting pins
	localparam logic LINE_MARK = 1'b1;
	localparam logic LINE_SPACE = 1'b0;

	typedef enum logic [1:0] {
		STERM_IDLE = 2'b00,
		STERM_TX = 2'b01,
		STERM_RX = 2'b10,
		STERM_ECHO = 2'b11
	} sterm_mode_e;

endpackage

/* logic/sterm_bitclk.sv */
// Half-bit tick divider with restart for receive alignment
`timescale 1ns/1ns
`default_nettype none
module sterm_bitclk #(
	parameter int HALF_CYC = 4
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic RESTART,
	output logic TICK
);
	typedef struct packed {
		logic [31:0] cnt;
	} sterm_div_s;

	sterm_div_s s;
	sterm_div_s next_s;

	// Free-running unless RESTART zeroes the count, so transmit timing never drifts between frames
	always_comb begin
		next_s = s;
		if (RESTART || s.cnt == 32'(HALF_CYC - 1)) begin
			next_s.cnt = 32'h0;
		end else begin
			next_s.cnt = s.cnt + 32'h1;
		end
	end

	assign TICK = CE && !RESTART && (s.cnt == 32'(HALF_CYC - 1));

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			s <= '0;
		end else if (CE) begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

/* logic/sterm_ctrl.sv */
// Serial terminal controller: modes, transmit and receive framing
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module sterm_ctrl
	import sterm_pkg::*;
#(
	parameter int HALF_BIT_CYC = sterm_pkg::HALF_BIT_CYCLES
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic SELECT_TRANSMIT_PULSE,
	input wire logic SELECT_RECEIVE_PULSE,
	input wire logic SELECT_ECHO_PULSE,
	input wire logic FORCE_SPACING_PULSE,
	input wire logic LOAD_STROBE,
	input wire logic [sterm_pkg::DATA_BITS-1:0] LOAD_DATA,
	input wire logic READ_STROBE,
	output logic [sterm_pkg::DATA_BITS-1:0] RX_DATA,
	output logic [1:0] MODE,
	output logic BUSY,
	output logic COMPLETE,
	output logic TEST_LINE,
	output logic SERIAL_CHAR_INTERRUPT_N,
	input wire logic SERIAL_LINE_IN_N,
	output logic SERIAL_LINE_OUT_N,
	output logic SERIAL_LINE_COMMON
);
	import sterm_pkg::*;

	typedef struct packed {
		sterm_mode_e mode;
		logic spacing;
		logic busy;
		logic complete;
		logic pend;
		logic [DATA_BITS-1:0] pend_data;
		logic tx_on;
		logic [4:0] tx_h;
		logic [FRAME_BITS-1:0] tx_frame;
		logic rx_on;
		logic [4:0] rx_h;
		logic [DATA_BITS-1:0] rx_sh;
		logic [DATA_BITS-1:0] rx_data;
		logic line;
	} sterm_state_s;

	localparam sterm_state_s RST_STATE = '{
		mode: STERM_IDLE, line: LINE_MARK, default: '0};

	sterm_state_s s;
	sterm_state_s next_s;
	logic tx_tick;
	logic rx_tick;
	logic rx_restart;
	logic line_in;
	logic tx_go;
	logic rx_go;
	logic clr;

	// Sync bit, data LSB first, two mark bits
	function automatic logic [FRAME_BITS-1:0] build_frame(
		input logic [DATA_BITS-1:0] d);
		build_frame = {{STOP_BITS{LINE_MARK}}, d, LINE_SPACE};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bit timing: transmit runs free, receive restarts on each sync edge
	sterm_bitclk #(.HALF_CYC(HALF_BIT_CYC)) u_tx_clk (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.CE(CE),
		.RESTART(1'b0),
		.TICK(tx_tick)
	);

	sterm_bitclk #(.HALF_CYC(HALF_BIT_CYC)) u_rx_clk (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.CE(CE),
		.RESTART(rx_restart),
		.TICK(rx_tick)
	);

	assign line_in = ~SERIAL_LINE_IN_N;
	assign tx_go = (s.mode == STERM_TX) || (s.mode == STERM_ECHO);
	assign rx_go = (s.mode == STERM_RX) || (s.mode == STERM_ECHO);
	assign clr = SELECT_TRANSMIT_PULSE || SELECT_RECEIVE_PULSE ||
		SELECT_ECHO_PULSE || FORCE_SPACING_PULSE || LOAD_STROBE ||
		READ_STROBE;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		rx_restart = 1'b0;
		// Clears come first so a same-cycle set wins
		if (clr) begin
			next_s.complete = 1'b0;
		end
		if (SELECT_TRANSMIT_PULSE) begin
			next_s.mode = STERM_TX;
			next_s.spacing = 1'b0;
		end else if (SELECT_RECEIVE_PULSE) begin
			next_s.mode = STERM_RX;
			next_s.spacing = 1'b0;
		end else if (SELECT_ECHO_PULSE) begin
			next_s.mode = STERM_ECHO;
			next_s.spacing = 1'b0;
		end
		if (FORCE_SPACING_PULSE && s.mode == STERM_TX) begin
			next_s.spacing = 1'b1;
		end

		// Transmitter
		if (tx_tick) begin
			if (s.tx_on) begin
				if (s.tx_h == LAST_HALF) begin
					if (s.pend && tx_go) begin
						next_s.tx_frame = build_frame(s.pend_data);
						next_s.tx_h = 5'h00;
						next_s.pend = 1'b0;
					end else begin
						next_s.tx_on = 1'b0;
					end
				end else begin
					next_s.tx_h = s.tx_h + 5'h01;
				end
				if (s.tx_h == DONE_HALF && s.mode == STERM_TX) begin
					next_s.complete = 1'b1;
				end
			end else if (s.pend && tx_go) begin
				next_s.tx_on = 1'b1;
				next_s.tx_frame = build_frame(s.pend_data);
				next_s.tx_h = 5'h00;
				next_s.pend = 1'b0;
			end
		end

		// Receiver: a tick with rx_h = k lands at half bit k + 1
		if (!s.rx_on) begin
			if (rx_go && line_in == LINE_SPACE) begin
				next_s.rx_on = 1'b1;
				next_s.rx_h = 5'h00;
				rx_restart = 1'b1;
			end
		end else if (rx_tick) begin
			next_s.rx_h = s.rx_h + 5'h01;
			// A glitch that is gone by mid sync bit is no frame
			if (s.rx_h == 5'h00 && line_in == LINE_MARK) begin
				next_s.rx_on = 1'b0;
			end
			if (s.rx_h >= FIRST_DATA_HALF && s.rx_h <= LAST_DATA_HALF &&
				!s.rx_h[0]) begin
				next_s.rx_sh = {line_in, s.rx_sh[DATA_BITS-1:1]};
			end
			if (s.rx_h == DONE_HALF) begin
				// Stop bits are not checked; half a bit remains to hunt
				next_s.rx_on = 1'b0;
				next_s.rx_data = s.rx_sh;
				next_s.complete = 1'b1;
				if (s.mode == STERM_ECHO) begin
					next_s.pend = 1'b1;
					next_s.pend_data = s.rx_sh;
				end
			end
		end
		if (!rx_go) begin
			next_s.rx_on = 1'b0;
		end

		// A processor load overrides an echo in the same cycle
		if (LOAD_STROBE) begin
			next_s.pend = 1'b1;
			next_s.pend_data = LOAD_DATA;
		end
		next_s.busy = next_s.tx_on || next_s.rx_on;
		if (next_s.spacing) begin
			next_s.line = LINE_SPACE;
		end else if (next_s.tx_on) begin
			next_s.line = next_s.tx_frame[next_s.tx_h[4:1]];
		end else begin
			next_s.line = LINE_MARK;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			s <= RST_STATE;
		end else if (CE) begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign RX_DATA = s.rx_data;
	assign MODE = s.mode;
	assign BUSY = s.busy;
	assign COMPLETE = s.complete;
	assign TEST_LINE = s.complete;
	assign SERIAL_CHAR_INTERRUPT_N = ~s.complete;
	assign SERIAL_LINE_OUT_N = ~s.line;
	assign SERIAL_LINE_COMMON = 1'b0;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	tx_select_a: assert property (CE && SELECT_TRANSMIT_PULSE |=>
		MODE == STERM_TX)
		else $error("transmit pulse did not select transmit");
	rx_select_a: assert property (CE && SELECT_RECEIVE_PULSE &&
		!SELECT_TRANSMIT_PULSE |=> MODE == STERM_RX)
		else $error("receive pulse did not select receive");
	echo_select_a: assert property (CE && SELECT_ECHO_PULSE &&
		!SELECT_TRANSMIT_PULSE && !SELECT_RECEIVE_PULSE |=>
		MODE == STERM_ECHO)
		else $error("echo pulse did not select echo");
	echo_resend_a: assert property (CE && rx_tick && s.rx_on &&
		s.rx_h == DONE_HALF |=> s.pend == (s.mode == STERM_ECHO ||
		$past(LOAD_STROBE)))
		else $error("echo resend wrong for mode");
	spacing_hold_a: assert property (s.spacing |->
		SERIAL_LINE_OUT_N && s.mode == STERM_TX)
		else $error("spacing not held on line");
	sync_bit_a: assert property (s.tx_on && !s.spacing &&
		s.tx_h[4:1] == 4'h0 |-> SERIAL_LINE_OUT_N)
		else $error("sync bit not spacing");
	stop_bits_a: assert property (s.tx_on && !s.spacing &&
		s.tx_h >= STOP_HALF |-> !SERIAL_LINE_OUT_N)
		else $error("stop bits not mark");
	rx_align_a: assert property (CE && !s.rx_on && rx_go &&
		!line_in |-> rx_restart ##1 s.rx_on && s.rx_h == 5'h00)
		else $error("receive not aligned to sync edge");
	back_to_back_a: assert property (tx_tick && s.tx_on &&
		s.tx_h == LAST_HALF && s.pend && tx_go && !s.spacing |=>
		s.tx_on && s.tx_h == 5'h00 && $stable(s.line) == 1'b0)
		else $error("gap between back to back frames");
	tx_done_a: assert property (tx_tick && s.tx_on &&
		s.tx_h == DONE_HALF && s.mode == STERM_TX |=>
		!SERIAL_CHAR_INTERRUPT_N && TEST_LINE && BUSY)
		else $error("completion missing at 10.5 bits");
	clear_a: assert property (CE && READ_STROBE && !tx_tick &&
		!rx_tick |=> !COMPLETE)
		else $error("read did not clear completion");


	////////////////////////////////////////////////////////////////////////
	// Mode and spacing: only a select pulse moves the mode; a spacing pulse opens the line in transmit only
	spacing_force_a: assert property (CE && FORCE_SPACING_PULSE &&
		s.mode == STERM_TX && !SELECT_TRANSMIT_PULSE &&
		!SELECT_RECEIVE_PULSE && !SELECT_ECHO_PULSE |=> SERIAL_LINE_OUT_N)
		else $error("spacing pulse did not open the line");
	spacing_ignore_a: assert property (CE && FORCE_SPACING_PULSE &&
		s.mode != STERM_TX && !SELECT_TRANSMIT_PULSE |=> !s.spacing)
		else $error("spacing taken outside transmit");
	mode_hold_a: assert property (!SELECT_TRANSMIT_PULSE &&
		!SELECT_RECEIVE_PULSE && !SELECT_ECHO_PULSE |=> $stable(MODE))
		else $error("mode changed without a pulse");
	idle_mark_a: assert property (!s.tx_on && !s.spacing |->
		!SERIAL_LINE_OUT_N)
		else $error("idle line not at mark");

	// Transmit start: the sync bit follows the divider tick directly
	tx_start_a: assert property (CE && tx_tick && !s.tx_on &&
		s.pend && tx_go |=> s.tx_on && SERIAL_LINE_OUT_N)
		else $error("loaded character did not start");

	// Receive framing
	rx_false_a: assert property (CE && rx_tick && s.rx_on &&
		s.rx_h == 5'h00 && line_in == LINE_MARK |=> !s.rx_on)
		else $error("false start not rejected");
	rx_sample_a: assert property (CE && rx_tick && s.rx_on &&
		s.rx_h == LAST_DATA_HALF |=> s.rx_sh[DATA_BITS-1] == $past(line_in))
		else $error("last data bit not sampled");
	rx_done_a: assert property (CE && rx_tick && s.rx_on &&
		s.rx_h == DONE_HALF |=> COMPLETE && RX_DATA == $past(s.rx_sh))
		else $error("receive completion missing");

	// Completion is sticky until the processor acts
	complete_hold_a: assert property (COMPLETE && !clr |=>
		COMPLETE)
		else $error("completion lost without a clear");
	pulse_clear_a: assert property (CE && SELECT_RECEIVE_PULSE &&
		!tx_tick && !rx_tick |=> !COMPLETE)
		else $error("pulse did not clear completion");

	// Clock enable low freezes every bit of state
	freeze_a: assert property (!CE |=> $stable(s))
		else $error("state moved with clock enable low");

	back_c: cover property (tx_tick && s.tx_on && s.tx_h == LAST_HALF &&
		s.pend && tx_go);
	tx_frame_c: cover property (tx_tick && s.tx_on && s.tx_h == DONE_HALF);
	rx_frame_c: cover property (rx_tick && s.rx_on && s.rx_h == DONE_HALF);
	echo_c: cover property (s.mode == STERM_ECHO && s.tx_on && s.rx_on);
	space_c: cover property (s.spacing);
endmodule
`default_nettype wire

/* sim/sterm_term.sv */
// Behavioural terminal on the far side of the serial lines
`timescale 1ns/1ns
`default_nettype none
module sterm_term #(
	parameter int HALF = 4
) (
	input wire logic CLOCK,
	input wire logic LINE_FROM_DEV_N,
	output logic LINE_TO_DEV_N
);
	logic [9:0] got_q[$];
	longint start_q[$];
	logic [9:0] fr;
	initial LINE_TO_DEV_N = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Sends one frame; the last mark bit leaves the line idle
	task automatic send(input logic [7:0] d);
		logic [10:0] bits;
		bits = {2'b11, d, 1'b0};
		@(posedge CLOCK);
		for (int i = 0; i < 11; i++) begin
			LINE_TO_DEV_N <= ~bits[i];
			repeat (2 * HALF) @(posedge CLOCK);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Samples mid-bit; stop bits kept so framing can be judged later
	always begin
		@(posedge LINE_FROM_DEV_N);
		start_q.push_back($time);
		repeat (HALF) @(posedge CLOCK);
		for (int i = 0; i < 10; i++) begin
			repeat (2 * HALF) @(posedge CLOCK);
			fr[i] = ~LINE_FROM_DEV_N;
		end
		got_q.push_back(fr);
	end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking testbench of the serial terminal controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sterm_pkg::*;
	localparam int HALF = 4;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [5:0] ctl = 6'h00;
	logic [7:0] load_data = 8'h00;
	logic [7:0] rx_data;
	logic [1:0] mode;
	logic busy, complete, test_line, int_n, out_n, common, in_n;
	int n_mismatch = 0;
	int tests_run = 0;
	int nq;
	always #5 clock = ~clock;
	sterm_ctrl #(.HALF_BIT_CYC(HALF)) dut_u (
		.CLOCK(clock), .SRST(srst), .CE(ce),
		.SELECT_TRANSMIT_PULSE(ctl[0]), .SELECT_RECEIVE_PULSE(ctl[1]),
		.SELECT_ECHO_PULSE(ctl[2]), .FORCE_SPACING_PULSE(ctl[3]),
		.LOAD_STROBE(ctl[4]), .LOAD_DATA(load_data),
		.READ_STROBE(ctl[5]), .RX_DATA(rx_data), .MODE(mode),
		.BUSY(busy), .COMPLETE(complete), .TEST_LINE(test_line),
		.SERIAL_CHAR_INTERRUPT_N(int_n), .SERIAL_LINE_IN_N(in_n),
		.SERIAL_LINE_OUT_N(out_n), .SERIAL_LINE_COMMON(common)
	);
	sterm_term #(.HALF(HALF)) term_u (
		.CLOCK(clock),
		.LINE_FROM_DEV_N(out_n),
		.LINE_TO_DEV_N(in_n)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bits 0-3 control pulses, 4 load, 5 read; one cycle wide
	task automatic strobe(input int i, input logic [7:0] d);
		@(posedge clock);
		ctl[i] <= 1'b1;
		load_data <= d;
		@(posedge clock);
		ctl <= 6'h00;
		#1;
	endtask
	// Bounded wait so a missing completion cannot hang the run
	task automatic wait_done();
		int n;
		n = 0;
		while (complete !== 1'b1 && n < 400) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk({15'h0000, complete}, 16'h0001);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		chk({1'b0, mode, complete, test_line, int_n, out_n, common, rx_data},
			16'h0400);
		chk({15'h0, busy}, 16'h0000);
		strobe(0, 8'h00);
		chk({14'h0, mode}, 16'h0001);
		strobe(4, 8'ha5);
		repeat (8) @(posedge clock);
		#1;
		chk({15'h0, busy}, 16'h0001);
		wait_done();
		chk({14'h0, test_line, int_n}, 16'h0002);
		// Load inside the last half bit: no gap allowed
		strobe(4, 8'h3c);
		wait_done();
		repeat (10) @(posedge clock);
		strobe(3, 8'h00);
		repeat (8) @(posedge clock);
		#1;
		chk({15'h0, out_n}, 16'h0001);
		strobe(1, 8'h00);
		chk({13'h0, mode, out_n}, 16'h0004);
		strobe(3, 8'h00);
		chk({15'h0, out_n}, 16'h0000);
		repeat (90) @(posedge clock);
		nq = term_u.got_q.size();
		strobe(5, 8'h00);
		chk({15'h0, complete}, 16'h0000);
		term_u.send(8'h96);
		wait_done();
		chk({8'h00, rx_data}, 16'h0096);
		repeat (100) @(posedge clock);
		chk(16'(term_u.got_q.size()), 16'(nq));
		strobe(5, 8'h00);
		strobe(2, 8'h00);
		chk({14'h0, mode}, 16'h0003);
		term_u.send(8'h5a);
		wait_done();
		repeat (100) @(posedge clock);
		chk({6'h00, term_u.got_q[$]}, 16'h035a);
		// A pulse with clock enable low must be ignored
		@(posedge clock);
		ce <= 1'b0;
		strobe(0, 8'h00);
		chk({14'h0, mode}, 16'h0003);
		@(posedge clock);
		ce <= 1'b1;
		chk({6'h00, term_u.got_q[0]}, 16'h03a5);
		chk({6'h00, term_u.got_q[1]}, 16'h033c);
		chk(16'(term_u.start_q[1] - term_u.start_q[0]), 16'd880);
		summarize();
	end
endmodule
`default_nettype wire
